// ==== rtl/hbsc_map.svh ====
`ifndef HBSC_MAP_SVH
`define HBSC_MAP_SVH
`define HBSC_WORD_W 16
`define HBSC_CTRL_RESET 16'hE000
`define HBSC_BIT_CLEAR 0
`define HBSC_BIT_SW_LO 1
`define HBSC_BIT_PWM_LO 7
`define HBSC_BIT_OL_CHECK_N 13
`define HBSC_BIT_OC_EN 14
`define HBSC_BIT_RUN 15
`define HBSC_ST_THERM 0
`define HBSC_ST_SW_LO 1
`define HBSC_ST_OVL 13
`define HBSC_ST_STBY 14
`define HBSC_ST_PSF 15
`endif

// ==== rtl/hbsc_pkg.sv ====
package hbsc_pkg;
    typedef logic [15:0] hbsc_word_t;
endpackage

// ==== rtl/hbsc_top.sv ====
// Functional notes
// - select_n falling edge starts a new serial frame.
// - serial_in is sampled on each falling serial clock edge.
// - new control word takes effect only at select_n rising edge.
// - serial_out tri-stated while select_n high, enabled on its falling edge.
// - serial_out changes on rising serial clock edges, stable between.
// - status word shifted out lsb first, thermal_warning first.
// - control bit 0 high clears supply_fail_flag and overload_flag.
// - control bits 1..6 switch the six switches on.
// - control bits 7..12 add pwm gating to matching switch.
// - control bit 13 low enables open-load detection.
// - control bit 14 high enables overcurrent shutdown.
// - control bit 15 low means standby; serial link keeps working.
// - status bit 0 reports thermal prewarning.
// - status bits 1..6 show switch state or open load; not cleared.
// - status bit 13 set when a switch is shut off by a fault.
// - status bit 14 is inverse of run_enable.
// - status bit 15 set on power-stage undervoltage.
// - each frame is 16 control bits in and 16 status bits out.
// - control word resets to bits 15, 14, 13 high.
// - supply_fail_flag stays set until status_clear executes.
`include "hbsc_map.svh"
module hbsc_top
    import hbsc_pkg::*;
#(
    parameter int WORD_W = `HBSC_WORD_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic sclk_i,
    input wire logic select_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    input wire logic thermal_warning_i,
    input wire logic undervoltage_i,
    input wire logic [5:0] fault_off_i,
    input wire logic [5:0] open_load_i,
    output logic [5:0] switch_on_o,
    output logic [5:0] pwm_gate_o,
    output logic open_load_check_n_o,
    output logic overcurrent_cutoff_en_o,
    output logic run_enable_o
);
    if (WORD_W != 16) begin : g_bad_width
        $error("hbsc_top: word width must be 16");
    end

    // link domain: clocked by sclk, frame bounded by select_n
    hbsc_word_t shift_in_r;
    hbsc_word_t shift_out_r;
    logic [4:0] bit_cnt_r;
    logic frame_tgl_r;
    hbsc_word_t frame_word_r;
    logic out_bit_r;
    hbsc_word_t status_r;

    // sampling on falling sclk; select_n high resets the link state, so a short frame is harmless
    always_ff @(negedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            shift_in_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
        end else begin
            shift_in_r <= {serial_in_i, shift_in_r[15:1]};
            if (bit_cnt_r != 5'h10) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // frame end: capture word and toggle for the system domain
    always_ff @(posedge select_n_i or posedge reset_i) begin
        if (reset_i) begin
            frame_word_r <= 16'h0000;
            frame_tgl_r <= 1'b0;
        end else if (bit_cnt_r == 5'h10) begin
            frame_word_r <= shift_in_r;
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    // status snapshot taken at select_n fall, lsb reaches the pin at the first rising sclk
    always_ff @(negedge select_n_i or posedge reset_i) begin
        if (reset_i) begin
            shift_out_r <= 16'h0000;
        end else begin
            shift_out_r <= status_r;
        end
    end

    logic [3:0] out_idx_r;
    always_ff @(posedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            out_idx_r <= 4'h0;
        end else if (out_idx_r != 4'hF) begin
            out_idx_r <= out_idx_r + 4'h1;
        end
    end

    // bit the pin drives at the next rising sclk, watched from the system domain by a cover only
    always_comb begin
        out_bit_r = shift_out_r[out_idx_r];
    end

    // system domain
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic sel_s2_r;
    logic out_s2_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else if (clk_en_i) begin
            tgl_s1_r <= frame_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end
    wire frame_done = tgl_s2_r ^ tgl_s3_r;

    hbsc_word_t ctrl_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_r <= `HBSC_CTRL_RESET;
        end else if (clk_en_i && frame_done) begin
            ctrl_r <= frame_word_r;
        end
    end

    logic clear_pulse_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            clear_pulse_r <= 1'b0;
        end else if (clk_en_i) begin
            clear_pulse_r <= frame_done && frame_word_r[`HBSC_BIT_CLEAR];
        end
    end

    logic therm_s2_r, uv_s2_r;
    logic [5:0] flt_s2_r, ol_s2_r;

    hbsc_sync2 #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_sync_therm (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .d_i(thermal_warning_i),
        .q_o(therm_s2_r)
    );

    hbsc_sync2 #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_sync_uv (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .d_i(undervoltage_i),
        .q_o(uv_s2_r)
    );

    hbsc_sync2 #(
        .WIDTH(6),
        .INIT(6'h00)
    ) u_sync_flt (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .d_i(fault_off_i),
        .q_o(flt_s2_r)
    );

    hbsc_sync2 #(
        .WIDTH(6),
        .INIT(6'h00)
    ) u_sync_ol (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .d_i(open_load_i),
        .q_o(ol_s2_r)
    );

    // latched shutoffs; released by status_clear like the overload flag
    logic [5:0] tripped_r;
    logic ovl_r, psf_r;
    wire [5:0] trip_now = flt_s2_r & ctrl_r[6:1];
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tripped_r <= 6'h00;
            ovl_r <= 1'b0;
            psf_r <= 1'b0;
        end else if (clk_en_i) begin
            // set wins over clear
            tripped_r <= (clear_pulse_r ? 6'h00 : tripped_r) | trip_now;
            ovl_r <= (ovl_r && !clear_pulse_r) || (trip_now != 6'h00);
            psf_r <= (psf_r && !clear_pulse_r) || uv_s2_r;
        end
    end

    wire run = ctrl_r[`HBSC_BIT_RUN];
    wire [5:0] sw_eff = ctrl_r[6:1] & ~tripped_r & {6{run && !uv_s2_r}};
    wire ol_mode = !ctrl_r[`HBSC_BIT_OL_CHECK_N];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            status_r <= 16'h0000;
        end else if (clk_en_i) begin
            status_r <= 16'h0000;
            status_r[`HBSC_ST_THERM] <= therm_s2_r;
            status_r[6:1] <= ol_mode ? (ol_s2_r & ~sw_eff) : sw_eff;
            status_r[`HBSC_ST_OVL] <= ovl_r;
            status_r[`HBSC_ST_STBY] <= !run;
            status_r[`HBSC_ST_PSF] <= psf_r;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            switch_on_o <= 6'h00;
            pwm_gate_o <= 6'h00;
            open_load_check_n_o <= 1'b1;
            overcurrent_cutoff_en_o <= 1'b1;
            run_enable_o <= 1'b1;
        end else if (clk_en_i) begin
            switch_on_o <= sw_eff;
            pwm_gate_o <= ctrl_r[12:7];
            open_load_check_n_o <= ctrl_r[`HBSC_BIT_OL_CHECK_N];
            overcurrent_cutoff_en_o <= ctrl_r[`HBSC_BIT_OC_EN];
            run_enable_o <= run;
        end
    end

    // serial pin driver on the link clock so the pin follows sclk and select_n directly
    always_ff @(posedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            serial_out_o <= 1'b0;
        end else begin
            // limitation: the pin reads low until the first rising sclk of a frame
            serial_out_o <= shift_out_r[out_idx_r];
        end
    end
    always_ff @(negedge select_n_i or posedge select_n_i or posedge reset_i) begin
        if (reset_i || select_n_i) begin
            serial_out_oe_n_o <= 1'b1;
        end else begin
            serial_out_oe_n_o <= 1'b0;
        end
    end

    // the select_n level is only used for cover statistics here
    hbsc_sync2 #(
        .WIDTH(1),
        .INIT(1'b1)
    ) u_sync_sel (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .d_i(select_n_i),
        .q_o(sel_s2_r)
    );

    hbsc_sync2 #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_sync_out (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .d_i(out_bit_r),
        .q_o(out_s2_r)
    );

    chk_ovl_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && clear_pulse_r && trip_now == 6'h00 |=> !ovl_r) else $error("overload flag not cleared");
    chk_psf_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && psf_r && !clear_pulse_r |=> psf_r) else $error("supply fail flag dropped");
    chk_psf_set: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && uv_s2_r |=> psf_r) else $error("supply fail flag not set");
    chk_ctrl_load: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && frame_done |=> ctrl_r == $past(frame_word_r)) else $error("control word not loaded");
    chk_ctrl_stable: assert property (@(posedge clk_i) disable iff (reset_i)
        !frame_done |=> $stable(ctrl_r)) else $error("control word changed outside frame end");
    chk_stby_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> status_r[`HBSC_ST_STBY] == !$past(run)) else $error("standby flag wrong");
    chk_standby_off: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && !run |=> switch_on_o == 6'h00) else $error("switch on in standby");
    chk_trip_ovl: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && trip_now != 6'h00 |=> ovl_r) else $error("overload not flagged");
    chk_oe_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        select_n_i |-> serial_out_oe_n_o) else $error("serial out driven while deselected");
    chk_oe_active: assert property (@(posedge clk_i) disable iff (reset_i)
        !select_n_i |-> !serial_out_oe_n_o) else $error("serial out not driven while selected");
    chk_sw_map: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> switch_on_o == $past(sw_eff)) else $error("switch outputs wrong");
    chk_pwm_map: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> pwm_gate_o == $past(ctrl_r[12:7])) else $error("pwm gating outputs wrong");
    chk_olc_map: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> open_load_check_n_o == $past(ctrl_r[`HBSC_BIT_OL_CHECK_N])) else $error("open load mode wrong");
    chk_oc_map: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> overcurrent_cutoff_en_o == $past(ctrl_r[`HBSC_BIT_OC_EN])) else $error("cutoff enable wrong");
    chk_run_map: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> run_enable_o == $past(run)) else $error("run enable wrong");
    chk_therm_stat: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> status_r[`HBSC_ST_THERM] == $past(therm_s2_r)) else $error("thermal status wrong");
    chk_ol_stat: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && ol_mode |=> status_r[6:1] == $past(ol_s2_r & ~sw_eff)) else $error("open load status wrong");
    chk_uv_off: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && uv_s2_r |=> switch_on_o == 6'h00) else $error("switch on during undervoltage");
    chk_trip_latch: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && trip_now != 6'h00 |=> (tripped_r & $past(trip_now)) == $past(trip_now))
        else $error("trip not latched");
    chk_psf_stat: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> status_r[`HBSC_ST_PSF] == $past(psf_r)) else $error("supply fail status wrong");
    chk_frame_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && frame_done ##1 clk_en_i |-> !frame_done) else $error("frame end seen twice");
    cov_frame: cover property (@(posedge clk_i) disable iff (reset_i) frame_done);
    cov_clear: cover property (@(posedge clk_i) disable iff (reset_i) clear_pulse_r && psf_r);
    cov_trip: cover property (@(posedge clk_i) disable iff (reset_i) trip_now != 6'h00);
    cov_ol: cover property (@(posedge clk_i) disable iff (reset_i) ol_mode && out_s2_r);
    cov_standby: cover property (@(posedge clk_i) disable iff (reset_i) !sel_s2_r && !run);
endmodule // hbsc_top

module hbsc_sync2
    import hbsc_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic en_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    if (WIDTH < 1) begin : g_bad_width
        $error("hbsc_sync2: width must be at least 1");
    end

    // two stages against metastability; only q_o may be read outside
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= INIT;
            q_o <= INIT;
        end else if (en_i) begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // hbsc_sync2

// ==== tb/hbsc_master.sv ====
module hbsc_master (
    output logic sclk_o,
    output logic select_n_o,
    output logic serial_in_o,
    input wire logic serial_out_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    // clock stands low outside frames; data line is driven low between frames
    task automatic frame(input logic [15:0] ctrl, input int nbits, output logic [15:0] st);
        st = 16'h0000;
        // keep link edges off the system clock edges
        #7;
        select_n_o = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            sclk_o = 1'b1;
            serial_in_o = ctrl[i];
            #80;
            sclk_o = 1'b0;
            st[i] = serial_out_i;
            #80;
        end
        select_n_o = 1'b1;
        serial_in_o = 1'b0;
        #400;
    endtask
endmodule // hbsc_master

// ==== tb/half_bridge_serial_control_tb.sv ====
module half_bridge_serial_control_tb;
    import hbsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic reset_i;
    logic en = 1'b1;
    logic therm = 1'b0;
    logic uv = 1'b0;
    logic [5:0] fault = 6'h00;
    logic [5:0] ol = 6'h00;
    logic sclk, sel_n, sdi, sdo, oe_n, olc_n, oc_en, run;
    logic [5:0] sw, pwm;
    int n_errors = 0;
    int cmp_count = 0;
    hbsc_word_t st;
    always #25 clk_i = ~clk_i;
    hbsc_master u_mst (.sclk_o(sclk), .select_n_o(sel_n), .serial_in_o(sdi), .serial_out_i(sdo));
    hbsc_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(en), .sclk_i(sclk), .select_n_i(sel_n),
        .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_n_o(oe_n), .thermal_warning_i(therm),
        .undervoltage_i(uv), .fault_off_i(fault), .open_load_i(ol), .switch_on_o(sw), .pwm_gate_o(pwm),
        .open_load_check_n_o(olc_n), .overcurrent_cutoff_en_o(oc_en), .run_enable_o(run));
    function automatic hbsc_word_t outs();
        return {run, oc_en, olc_n, pwm, sw, 1'b0};
    endfunction
    task automatic cmp_word(input hbsc_word_t got, input hbsc_word_t exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // fixed settle time covers the frame toggle sync, control load and output register
    task automatic xfer(input hbsc_word_t c, input int n);
        u_mst.frame(c, n, st);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic set_in(input logic t, input logic u, input logic [5:0] f, input logic [5:0] o);
        @(posedge clk_i);
        therm <= t;
        uv <= u;
        fault <= f;
        ol <= o;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_reset();
        cmp_word(outs(), 16'hE000, "reset control");
        cmp_word({15'h0000, oe_n}, 16'h0001, "idle output enable");
        $display("test reset done");
    endtask
    task automatic t_switch();
        xfer(16'hA07E, 16);
        cmp_word(outs(), 16'hA07E, "switches on");
        cmp_word({15'h0000, oe_n}, 16'h0001, "released output enable");
        set_in(1'b1, 1'b0, 6'h00, 6'h00);
        xfer(16'h9F80, 16);
        cmp_word(st, 16'h007F, "switch status");
        cmp_word(outs(), 16'h9F80, "pwm and modes");
        $display("test switch done");
    endtask
    task automatic t_short();
        set_in(1'b1, 1'b0, 6'h00, 6'h2A);
        xfer(16'h0000, 8);
        cmp_word({8'h00, st[7:0]}, 16'h0055, "open load short read");
        cmp_word(outs(), 16'h9F80, "short frame ignored");
        $display("test short done");
    endtask
    task automatic t_fault();
        set_in(1'b0, 1'b0, 6'h00, 6'h00);
        xfer(16'hE002, 16);
        set_in(1'b0, 1'b1, 6'h01, 6'h00);
        xfer(16'hE002, 16);
        cmp_word(st, 16'hA000, "fault flags");
        set_in(1'b0, 1'b0, 6'h00, 6'h00);
        xfer(16'hE003, 16);
        cmp_word(st, 16'hA000, "flags held");
        xfer(16'h6000, 16);
        cmp_word(st, 16'h0002, "flags cleared");
        xfer(16'h6000, 16);
        cmp_word(st, 16'h4000, "standby status");
        cmp_word(outs(), 16'h6000, "standby control");
        $display("test fault done");
    endtask
    task automatic t_hold();
        @(posedge clk_i);
        en <= 1'b0;
        xfer(16'hE000, 16);
        cmp_word(outs(), 16'h6000, "frozen control");
        @(posedge clk_i);
        en <= 1'b1;
        repeat (8) @(posedge clk_i);
        cmp_word(outs(), 16'hE000, "released control");
        $display("test hold done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        reset_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_switch();
        t_short();
        t_fault();
        t_hold();
        tally_and_finish();
    end
    // hang guard: a run past this bound is counted as a mismatch
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end
endmodule // half_bridge_serial_control_tb
